//--- rtpd_pkg.sv
// Purpose: Constants for the receive test-pattern detector
// Assumes: 8-bit registers inside one framer register bank
// Notes:   Pattern codes follow the 4-bit pattern select field
// ============================================================
// Package
package rtpd_pkg;
  localparam logic [7:0] CTRL_ADDR      = 8'ha6;
  localparam logic [7:0] STATUS_ADDR    = 8'ha7;
  localparam logic [7:0] CTRL_RESET     = 8'h00;
  localparam logic [7:0] STATUS_RESET   = 8'h00;
  localparam int         INV_BIT        = 0;
  localparam int         EN_BIT         = 2;
  localparam int         UNF_BIT        = 3;
  localparam int         SEL_LSB        = 4;
  localparam int         ST_LOCK_BIT    = 0;
  localparam int         ST_ERR_BIT     = 1;
  localparam int         ST_FOUND_BIT   = 2;
  localparam int         LOCK_COUNT_DEF = 32;
  localparam int         QRSS_ZERO_RUN  = 14;
  localparam logic [3:0] SEL_MARK       = 4'h0;
  localparam logic [3:0] SEL_QRSS       = 4'h1;
  localparam logic [3:0] SEL_LAST_PRBS  = 4'hb;
  localparam logic [3:0] SEL_ALT        = 4'hc;
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_SEARCH = 3'b010,
    ST_LOCK   = 3'b100
  } rtpd_state_e;
endpackage : rtpd_pkg

//--- rtpd_detector.sv
// Purpose: Receive test-pattern detector with control and status registers
// Assumes: Line bits arrive as strobes from framer logic on core_clk
// Notes:   Lock after LOCK_COUNT consecutive matching bits
//
// Behaviour
// - Control register resets to zero; detector idle, code 0000 (mark) selected.
// - Writing zero to control clears the status register.
// - Once locked, alignment holds and every differing bit is a bit error.
// - No realignment while locked until control cleared and reprogrammed.
// - Invert bit set makes the detector expect the inverted pattern.
// - Block select bit enables detection; clear means no detection.
// - Unframed search uses all bits; framed search uses payload bits only.
// - Upper four bits select the fixed or pseudo-random sequence.
// - One code expects continuous all-ones mark sequence.
// - Code 0001 expects QRSS from taps 17 and 20 with zero suppression.
module rtpd_detector
  import rtpd_pkg::*;
#(
  parameter int LOCK_COUNT = LOCK_COUNT_DEF
) (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  // Register access
  input  wire logic       regWrEn,
  input  wire logic       regRdEn,
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWrData,
  output logic      [7:0] regRdData,
  // Received line bits
  input  wire logic       rxBit,
  input  wire logic       rxBitValid,
  input  wire logic       rxPayload,
  // Detector state
  output logic            patternLocked,
  output logic            bitErrorPulse
);

  // ============================================================
  // Parameter check
  generate
    if (LOCK_COUNT < 2 || LOCK_COUNT > 255) begin : g_bad_count
      $error("LOCK_COUNT must lie in 2..255");
    end
  endgenerate

  localparam logic [7:0] LOCK_LAST = 8'(LOCK_COUNT - 1);

  // ============================================================
  // Declarations
  logic [7:0]  ctrlReg;
  logic        statErrReg;
  logic        statFoundReg;
  rtpd_state_e stReg;
  rtpd_state_e stNext;
  logic [22:0] histReg;
  logic [7:0]  matchCntReg;
  logic [3:0]  sel;
  logic        ctrlWr;
  logic        clearWr;
  logic        useBit;
  logic        dataBit;
  logic        prbsBit;
  logic        expBit;
  logic        selValid;
  logic        match;
  logic        lockEvent;
  logic        errEvent;
  logic [4:0]  tapA;
  logic [4:0]  tapB;

  assign sel     = ctrlReg[SEL_LSB +: 4];
  assign ctrlWr  = regWrEn && regAddr == CTRL_ADDR;
  assign clearWr = ctrlWr && regWrData == CTRL_RESET;
  assign dataBit = rxBit ^ ctrlReg[INV_BIT];
  assign useBit  = rxBitValid && ctrlReg[EN_BIT] && stReg != ST_IDLE
                   && (ctrlReg[UNF_BIT] || rxPayload);
  assign match     = dataBit == expBit;
  assign lockEvent = stReg == ST_SEARCH && useBit && match && selValid
                     && matchCntReg == LOCK_LAST;
  assign errEvent  = stReg == ST_LOCK && useBit && !match;

  // ============================================================
  // Sequence taps per pattern code
  always_comb begin
    tapA     = 5'd1;
    tapB     = 5'd1;
    selValid = 1'b1;
    unique case (sel)
      4'h1:    begin tapA = 5'd17; tapB = 5'd20; end
      4'h2:    begin tapA = 5'd3;  tapB = 5'd5;  end
      4'h3:    begin tapA = 5'd1;  tapB = 5'd6;  end
      4'h4:    begin tapA = 5'd5;  tapB = 5'd9;  end
      4'h5:    begin tapA = 5'd4;  tapB = 5'd9;  end
      4'h6:    begin tapA = 5'd9;  tapB = 5'd11; end
      4'h7:    begin tapA = 5'd2;  tapB = 5'd11; end
      4'h8:    begin tapA = 5'd14; tapB = 5'd15; end
      4'h9:    begin tapA = 5'd3;  tapB = 5'd20; end
      4'ha:    begin tapA = 5'd17; tapB = 5'd20; end
      4'hb:    begin tapA = 5'd18; tapB = 5'd23; end
      4'h0, 4'hc: selValid = 1'b1;
      default: selValid = 1'b0;
    endcase
  end

  // Expected bit from the local generator state
  always_comb begin
    prbsBit = histReg[tapA - 5'd1] ^ histReg[tapB - 5'd1];
    if (sel == SEL_MARK) begin
      expBit = 1'b1;
    end else if (sel == SEL_ALT) begin
      expBit = ~histReg[0];
    end else if (sel == SEL_QRSS) begin
      expBit = prbsBit | (histReg[QRSS_ZERO_RUN-1:0] == '0);
    end else begin
      expBit = prbsBit;
    end
  end

  // ============================================================
  // Control register; bit 1 stored but unused
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctrlReg <= CTRL_RESET;
    end else if (ctrlWr) begin
      ctrlReg <= regWrData;
    end
  end

  // ============================================================
  // Alignment state
  always_comb begin
    stNext = stReg;
    unique case (stReg)
      ST_IDLE:   if (ctrlReg[EN_BIT] && !clearWr) stNext = ST_SEARCH;
      ST_SEARCH: if (clearWr) stNext = ST_IDLE;
                 else if (lockEvent) stNext = ST_LOCK;
      ST_LOCK:   if (clearWr) stNext = ST_IDLE;
      default:   stNext = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      stReg         <= ST_IDLE;
      patternLocked <= 1'b0;
    end else begin
      stReg         <= stNext;
      patternLocked <= stNext == ST_LOCK;
    end
  end

  // Search follows the line; lock free-runs the generator
  always_ff @(posedge core_clk) begin
    if (rst) begin
      histReg <= '0;
    end else if (useBit) begin
      histReg <= {histReg[21:0],
                  stReg == ST_LOCK ? expBit : dataBit};
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst || clearWr) begin
      matchCntReg <= '0;
    end else if (stReg == ST_SEARCH && useBit) begin
      matchCntReg <= match ? matchCntReg + 8'h01 : 8'h00;
    end
  end

  // ============================================================
  // Status flags; a set wins over the clear
  always_ff @(posedge core_clk) begin
    if (rst) begin
      statErrReg    <= 1'b0;
      statFoundReg  <= 1'b0;
      bitErrorPulse <= 1'b0;
    end else begin
      bitErrorPulse <= errEvent;
      statErrReg    <= errEvent || (statErrReg && !clearWr);
      statFoundReg  <= lockEvent || (statFoundReg && !clearWr);
    end
  end

  // Registered read data
  always_ff @(posedge core_clk) begin
    if (rst) begin
      regRdData <= 8'h00;
    end else if (regRdEn && regAddr == CTRL_ADDR) begin
      regRdData <= ctrlReg;
    end else if (regRdEn && regAddr == STATUS_ADDR) begin
      regRdData <= {5'h00, statFoundReg, statErrReg, patternLocked};
    end else begin
      regRdData <= 8'h00;
    end
  end

  // ============================================================
  // Assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence lockCause;
    stReg == ST_SEARCH && lockEvent && !clearWr;
  endsequence
  sequence lockShown;
    patternLocked && stReg == ST_LOCK && statFoundReg;
  endsequence
  sequence searchHit;
    stReg == ST_SEARCH && useBit && match;
  endsequence
  sequence searchMiss;
    stReg == ST_SEARCH && useBit && !match;
  endsequence

  reset_ctrl_a: assert property (disable iff (1'b0)
    rst ##1 !rst && !$past(ctrlWr) |-> ctrlReg == 8'h00 && !patternLocked)
    else $error("control not zero after reset");
  clear_status_a: assert property (clearWr && !errEvent && !lockEvent
    |=> !statErrReg && !statFoundReg && !patternLocked)
    else $error("status not cleared by zero write");
  lock_hold_a: assert property (stReg == ST_LOCK && !clearWr |=>
    stReg == ST_LOCK)
    else $error("detector left lock without clear");
  error_report_a: assert property (errEvent |=>
    bitErrorPulse && statErrReg)
    else $error("mismatch not reported");
  invert_mark_a: assert property (stReg == ST_LOCK && useBit
    && sel == SEL_MARK && rxBit == ctrlReg[INV_BIT] |=> bitErrorPulse)
    else $error("inverted mark not checked");
  enable_off_a: assert property (!ctrlReg[EN_BIT] |=>
    !bitErrorPulse && $stable(histReg))
    else $error("detection while disabled");
  framed_skip_a: assert property (!ctrlReg[UNF_BIT] && !rxPayload
    |=> $stable(histReg) && !bitErrorPulse)
    else $error("overhead bit used in framed search");
  qrss_taps_a: assert property (stReg == ST_LOCK && useBit
    && sel == SEL_QRSS && histReg[13:0] != 14'h0000
    && dataBit != (histReg[16] ^ histReg[19]) |=> bitErrorPulse)
    else $error("qrss mismatch missed");
  lock_seq_a: assert property (lockCause |=> lockShown)
    else $error("lock not reported");

  // ============================================================
  // Search, status and read-back checks
  miss_restart_a: assert property (searchMiss |=>
    matchCntReg == 8'h00)
    else $error("search count not restarted");
  hit_count_a: assert property (searchHit && !clearWr |=>
    matchCntReg == $past(matchCntReg) + 8'h01)
    else $error("search count not advanced");
  zero_idle_a: assert property (clearWr |=>
    stReg == ST_IDLE && !patternLocked)
    else $error("zero write did not idle detector");
  no_err_unlocked_a: assert property (stReg != ST_LOCK |=>
    !bitErrorPulse)
    else $error("bit error while not locked");
  lock_level_a: assert property (patternLocked == (stReg == ST_LOCK))
    else $error("lock output differs from state");
  err_sticky_a: assert property (statErrReg && !clearWr |=>
    statErrReg)
    else $error("error flag lost without clear");
  found_sticky_a: assert property (statFoundReg && !clearWr |=>
    statFoundReg)
    else $error("found flag lost without clear");
  mark_expect_a: assert property (sel == SEL_MARK |-> expBit)
    else $error("mark pattern not all ones");
  bad_code_a: assert property (!selValid |-> !lockEvent)
    else $error("lock on unsupported code");
  status_read_a: assert property (
    regRdEn && regAddr == STATUS_ADDR |=> regRdData ==
    {5'h00, $past(statFoundReg), $past(statErrReg),
     $past(patternLocked)})
    else $error("status read back wrong");
  ctrl_read_a: assert property (
    regRdEn && regAddr == CTRL_ADDR |=> regRdData == $past(ctrlReg))
    else $error("control read back wrong");
  idle_quiet_a: assert property (stReg == ST_IDLE |=>
    !bitErrorPulse && !patternLocked)
    else $error("idle detector reported activity");

endmodule : rtpd_detector

//--- rtpd_line_src.sv
// Purpose: Line-side source of received bits for the detector bench
// Assumes: One strobed bit per call, same clock as the detector
// Notes:   Data line shows the inverse of the last bit between strobes
// ============================================================
// Line source
module rtpd_line_src (
  // Clock
  input  wire logic core_clk,
  // Line bits
  output logic      rxBit,
  output logic      rxBitValid,
  output logic      rxPayload
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    rxBit      = 1'b0;
    rxBitValid = 1'b0;
    rxPayload  = 1'b0;
  end
  task automatic send_bit(input logic b, input logic pay);
    @(posedge core_clk);
    #1;
    rxBit      = b;
    rxBitValid = 1'b1;
    rxPayload  = pay;
    @(posedge core_clk);
    #1;
    rxBitValid = 1'b0;
    rxBit      = ~b;
  endtask : send_bit
endmodule : rtpd_line_src

//--- tb_top.sv
// Purpose: Self-checking bench for the receive test-pattern detector
// Assumes: Small lock count so searches stay short
// Notes:   Bench model tracks lock, errors and sticky status
// ============================================================
// Bench
module tb_top;
  import rtpd_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int LC = 4;
  logic       core_clk, rst, regWrEn, regRdEn, idle, expLock, pay;
  logic [7:0] regAddr, regWrData, regRdData, ctrl, st;
  logic [22:0] hist, g;
  logic       rxBit, rxBitValid, rxPayload, patternLocked, bitErrorPulse;
  int         err_count, samples_checked, cycles, seed, run;
  rtpd_detector #(.LOCK_COUNT(LC)) DUT (.core_clk(core_clk), .rst(rst),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr),
    .regWrData(regWrData), .regRdData(regRdData), .rxBit(rxBit),
    .rxBitValid(rxBitValid), .rxPayload(rxPayload),
    .patternLocked(patternLocked), .bitErrorPulse(bitErrorPulse));
  rtpd_line_src LINE (.core_clk(core_clk), .rxBit(rxBit),
    .rxBitValid(rxBitValid), .rxPayload(rxPayload));
  task automatic chk_reg(input string nm, input logic [7:0] e, g);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_reg
  task automatic chk_flag(input string nm, input logic e, g);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_flag
  task automatic wr(input logic [7:0] a, d);
    @(posedge core_clk);
    #1;
    regWrEn   = 1'b1;
    regAddr   = a;
    regWrData = d;
    @(posedge core_clk);
    #1;
    regWrEn = 1'b0;
    if (a == CTRL_ADDR) begin
      idle = (d == 8'h00);
      ctrl = d;
      if (idle) begin
        expLock = 1'b0;
        run     = 0;
        st      = 8'h00;
      end
    end
  endtask : wr
  task automatic rd(input logic [7:0] a, e);
    @(posedge core_clk);
    #1;
    regRdEn = 1'b1;
    regAddr = a;
    @(posedge core_clk);
    #1;
    regRdEn = 1'b0;
    chk_reg("regRdData", e, regRdData);
  endtask : rd
  // One strobed bit through the bench model, then compare outputs
  task automatic sb(input logic b, input logic p);
    logic used, match, expErr, e;
    e      = (ctrl[7:4] == SEL_QRSS) ?
             ((hist[16] ^ hist[19]) | (hist[13:0] == 14'h0)) : 1'b1;
    used   = ~idle & ctrl[EN_BIT] & (ctrl[UNF_BIT] | p);
    match  = (b ^ ctrl[INV_BIT]) == e;
    expErr = used & expLock & ~match;
    if (used) hist = {hist[21:0], expLock ? e : (b ^ ctrl[INV_BIT])};
    if (used & ~expLock) begin
      run = match ? run + 1 : 0;
      if (run == LC) begin
        expLock          = 1'b1;
        st[ST_FOUND_BIT] = 1'b1;
      end
    end
    if (expErr) st[ST_ERR_BIT] = 1'b1;
    LINE.send_bit(b, p);
    chk_flag("patternLocked", expLock, patternLocked);
    chk_flag("bitErrorPulse", expErr, bitErrorPulse);
  endtask : sb
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : finish_test
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      finish_test();
    end
  end
  initial begin
    {regWrEn, regRdEn, regAddr, regWrData} = '0;
    {idle, expLock, ctrl, st, run, hist, g} = '0;
    idle = 1'b1;
    seed = 9975;
    rst  = 1'b1;
    repeat (4) @(posedge core_clk);
    #1;
    rst = 1'b0;
    rd(CTRL_ADDR, CTRL_RESET);
    rd(STATUS_ADDR, STATUS_RESET);
    rd(8'h55, 8'h00);
    for (int c = 0; c < 16; c++) begin
      wr(CTRL_ADDR, 8'h00);
      wr(CTRL_ADDR, {c[3:0], 4'h8});
      rd(CTRL_ADDR, {c[3:0], 4'h8});
    end
    wr(CTRL_ADDR, 8'h00);
    wr(CTRL_ADDR, 8'h0e);
    rd(CTRL_ADDR, 8'h0e);
    repeat (LC) sb(1'b1, 1'b0);
    sb(1'b0, 1'b0);
    repeat (LC + 2) sb(1'b0, 1'b0);
    rd(STATUS_ADDR, st | {7'h0, expLock});
    wr(CTRL_ADDR, 8'h00);
    rd(STATUS_ADDR, 8'h00);
    wr(CTRL_ADDR, 8'h0d);
    repeat (LC) sb(1'b0, 1'b0);
    sb(1'b1, 1'b0);
    wr(CTRL_ADDR, 8'h00);
    wr(CTRL_ADDR, 8'h04);
    for (int i = 0; i < 3 * LC; i++) begin
      pay = 1'($random(seed));
      sb(pay | 1'($random(seed)), pay);
    end
    repeat (LC + 1) sb(1'b1, 1'b1);
    rd(STATUS_ADDR, st | {7'h0, expLock});
    wr(CTRL_ADDR, 8'h00);
    wr(CTRL_ADDR, 8'h1c);
    g = 23'($random(seed));
    for (int i = 0; i < 40; i++) begin
      g = {g[21:0], (g[16] ^ g[19]) | (g[13:0] == 14'h0)};
      sb(g[0] ^ (i == 36), 1'b0);
    end
    rd(STATUS_ADDR, st | {7'h0, expLock});
    wr(CTRL_ADDR, 8'h00);
    wr(CTRL_ADDR, 8'h08);
    repeat (LC + 1) sb(1'b1, 1'b1);
    finish_test();
  end
endmodule : tb_top
